// [core/gpio_consts.svh]
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// port slots: 0..4 are ports 0..4, slot 5 is port 6
`define SLOT_COUNT 6
`define PORT_WIDTH 8
`define SLOT_P0 3'h0
`define SLOT_P3 3'h3
`define SLOT_P4 3'h4

// implemented direction bits per slot (port 3 lacks 2 and 6, port 4 lacks 0..2)
`define DIR_MASK_FULL 8'hff
`define DIR_MASK_P3 8'hbb
`define DIR_MASK_P4 8'hf8
// implemented data bits (port 4 bit 2 exists as an input only)
`define DATA_MASK_P3 8'hbb
`define DATA_MASK_P4 8'hfc
`define IN_ONLY_P4 8'h04
`define IN_ONLY_NONE 8'h00

// oscillator and converter pins inside port 4
`define SUB_CLOCK_PINS 8'h18
`define MAIN_CLOCK_PINS 8'hc0
`define ADC_PIN 8'h04

// reset values
`define DIR_RESET 8'h00
`define LATCH_RESET 8'h00
`define THRESHOLD_RESET 2'h0
`define THRESHOLD_RESERVED 2'h3

`endif

// [core/gpio_pkg.sv]
package gpio_pkg;
    // one cpu access to a port register
    typedef struct packed {
        logic write;         // one-cycle write strobe
        logic read;          // one-cycle read strobe
        logic isDirection;   // 1: direction register, 0: data register
        logic [2:0] port;    // port slot 0..5
        logic [7:0] data;    // write data
    } access_t;

    // pad settings held by software elsewhere
    typedef struct packed {
        logic [7:0] pullupSelectRegA;
        logic [3:0] pullupSelectRegB;
        logic [7:0] driveSelectPortB;
        logic [7:0] driveSelectPortC;
        logic [3:0] driveSelectGroupA;
        logic [3:0] driveSelectGroupB;
        logic [7:0] thresholdSelectA;
        logic [3:0] thresholdSelectB;
    } pad_cfg_t;

    // input threshold levels
    typedef enum logic [1:0] {
        TH_LOW = 2'b00,
        TH_MID = 2'b01,
        TH_HIGH = 2'b10
    } threshold_t;
endpackage

// [core/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 48
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage;  // first stage, read only by the second

    // width check at elaboration
    if (WIDTH < 1) begin : g_bad
        $error("pin_sync width must be positive");
    end

    // two flops per pin against metastability
    always_ff @(posedge clock) begin
        if (rst) begin
            stage <= '0;
            synced <= '0;
        end else begin
            stage <= async;
            synced <= stage;
        end
    end
endmodule

// [core/port_slice.sv]
`timescale 1ns/1ps
`include "gpio_consts.svh"
module port_slice #(
    parameter logic [7:0] DIR_MASK = 8'hff,
    parameter logic [7:0] DATA_MASK = 8'hff,
    parameter logic [7:0] IN_ONLY = 8'h00,
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic writeDir,
    input wire logic writeData,
    input wire logic [7:0] wdata,
    input wire logic [7:0] pinLevel,
    input wire logic [7:0] periphOe,
    input wire logic [7:0] periphOut,
    input wire logic [7:0] blocked,
    input wire logic [7:0] pullSel,
    output logic [7:0] dirBits,
    output logic [7:0] latch,
    output logic [7:0] readValue,
    output logic [7:0] padOut,
    output logic [7:0] padOe,
    output logic [7:0] pullOn
);
    logic [7:0] gpioPins;  // pins free for general use

    // only byte-wide ports are served
    if (WIDTH != 8) begin : g_bad
        $error("port_slice supports 8-bit ports only");
    end

    // absent bits never hold a one, so they read back as zero
    always_ff @(posedge clock) begin
        if (rst) begin
            dirBits <= `DIR_RESET;
            latch <= `LATCH_RESET;
        end else begin
            if (writeDir)
                dirBits <= wdata & DIR_MASK;
            if (writeData)
                latch <= wdata & DATA_MASK & ~IN_ONLY;
        end
    end

    assign gpioPins = ~blocked;
    // input mode reads the pin, output mode the latch
    assign readValue = DATA_MASK & gpioPins & ((dirBits & latch) | (~dirBits & pinLevel));
    // peripheral output drives regardless of direction
    assign padOe = DIR_MASK & gpioPins & (dirBits | periphOe);
    assign padOut = padOe & ((periphOe & periphOut) | (~periphOe & latch));
    // pull-up only while the pin is an input
    assign pullOn = DIR_MASK & gpioPins & pullSel & ~dirBits & ~periphOe;
endmodule

// [core/io_port_direction_latch.sv]
`timescale 1ns/1ps
`include "gpio_consts.svh"
// Overview of operation
// - one direction bit per pin, 1 is output
// - input mode reads the sampled pin level
// - output mode reads the output latch
// - writes always load latch; drive only in output
// - peripheral outputs drive whatever the direction
// - converter pin is input only, no extras
// - pull-up in input mode, in groups of up to four pins
// - drive strength low/high, per bit or group
// - three input thresholds per port
// - absent direction bits are not implemented
// - sub clock pins are GPIO only when idle
// - main clock pins are GPIO only when idle
// - absent bits read back as zero
// - port 0 direction needs prior unlock instruction
module io_port_direction_latch
    import gpio_pkg::*;
#(
    parameter int NUM_PORTS = 6
) (
    input wire logic clock,
    input wire logic rst,
    input wire access_t acc,
    input wire pad_cfg_t cfg,
    input wire logic protectSet,
    input wire logic instrEnd,
    input wire logic adcInUse,
    input wire logic subClockInUse,
    input wire logic mainClockInUse,
    input wire logic [5:0][7:0] pinIn,
    input wire logic [5:0][7:0] periphOe,
    input wire logic [5:0][7:0] periphOut,
    output logic [7:0] readData,
    output logic [5:0][7:0] pinOut,
    output logic [5:0][7:0] pinOutEn,
    output logic [5:0][7:0] pullupEn,
    output logic [5:0][7:0] driveHigh,
    output logic [5:0][1:0] thresholdLevel,
    output logic [5:0][7:0] periphIn
);
    // the slot mapping below is written for exactly six ports
    if (NUM_PORTS != `SLOT_COUNT) begin : g_bad
        $error("io_port_direction_latch needs six port slots");
    end

    logic [5:0][7:0] pinLevel;    // synchronised pin levels
    logic [5:0][7:0] dirState;    // direction bits per slot
    logic [5:0][7:0] latchState;  // output latches per slot
    logic [5:0][7:0] readValue;   // data read value per slot
    logic [5:0][7:0] padOut;      // next pin level
    logic [5:0][7:0] padOe;       // next output enable
    logic [5:0][7:0] pullOn;      // next pull-up enable
    logic [5:0][7:0] pullGroup;   // pull-up selection spread per pin
    logic [5:0][7:0] driveGroup;  // drive selection spread per pin
    logic [5:0][7:0] blocked;     // pins taken by oscillator or converter
    logic [5:0][1:0] thresholdCode; // requested threshold per slot
    logic [5:0] writeDirEn;       // direction write hits this slot
    logic [5:0] writeDataEn;      // data write hits this slot
    logic protectPending;         // unlock seen, its instruction still running
    logic protectWindow;          // next instruction may write port 0 direction
    logic next_protectWindow;
    logic portValid;              // addressed slot exists
    logic [7:0] selDir;           // direction byte of addressed slot
    logic [7:0] selData;          // data byte of addressed slot
    logic [7:0] next_readData;

    // pins arrive from outside the clock domain
    pin_sync #(
        .WIDTH(48)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .async(pinIn),
        .synced(pinLevel)
    );

    // pull-up groups: nibbles, port 3 in threes, port 4 bit 3 alone
    assign pullGroup[0] = {{4{cfg.pullupSelectRegA[1]}}, {4{cfg.pullupSelectRegA[0]}}};
    assign pullGroup[1] = {{4{cfg.pullupSelectRegA[3]}}, {4{cfg.pullupSelectRegA[2]}}};
    assign pullGroup[2] = {{4{cfg.pullupSelectRegA[5]}}, {4{cfg.pullupSelectRegA[4]}}};
    assign pullGroup[3] = {cfg.pullupSelectRegA[7], 1'b0, {2{cfg.pullupSelectRegA[7]}},
                           cfg.pullupSelectRegA[6], 1'b0, {2{cfg.pullupSelectRegA[6]}}};
    assign pullGroup[4] = {{4{cfg.pullupSelectRegB[1]}}, cfg.pullupSelectRegB[0], 3'h0};
    assign pullGroup[5] = {{4{cfg.pullupSelectRegB[3]}}, {4{cfg.pullupSelectRegB[2]}}};

    // drive strength: ports 1 and 2 per bit, the rest per group
    assign driveGroup[0] = {{4{cfg.driveSelectGroupA[1]}}, {4{cfg.driveSelectGroupA[0]}}};
    assign driveGroup[1] = cfg.driveSelectPortB;
    assign driveGroup[2] = cfg.driveSelectPortC;
    assign driveGroup[3] = {cfg.driveSelectGroupA[3], 1'b0, {2{cfg.driveSelectGroupA[3]}},
                            cfg.driveSelectGroupA[2], 1'b0, {2{cfg.driveSelectGroupA[2]}}};
    assign driveGroup[4] = {{4{cfg.driveSelectGroupB[1]}}, cfg.driveSelectGroupB[0], 3'h0};
    assign driveGroup[5] = {{4{cfg.driveSelectGroupB[3]}}, {4{cfg.driveSelectGroupB[2]}}};

    // threshold codes: slots 0..3 from the first setting, 4..5 from the second
    assign thresholdCode[0] = cfg.thresholdSelectA[1:0];
    assign thresholdCode[1] = cfg.thresholdSelectA[3:2];
    assign thresholdCode[2] = cfg.thresholdSelectA[5:4];
    assign thresholdCode[3] = cfg.thresholdSelectA[7:6];
    assign thresholdCode[4] = cfg.thresholdSelectB[1:0];
    assign thresholdCode[5] = cfg.thresholdSelectB[3:2];

    // oscillator pins leave general use while their oscillator runs, the converter pin while the converter is in use
    assign blocked[0] = 8'h00;
    assign blocked[1] = 8'h00;
    assign blocked[2] = 8'h00;
    assign blocked[3] = 8'h00;
    assign blocked[4] = ({8{subClockInUse}} & `SUB_CLOCK_PINS)
                      | ({8{mainClockInUse}} & `MAIN_CLOCK_PINS)
                      | ({8{adcInUse}} & `ADC_PIN);
    assign blocked[5] = 8'h00;

    // unlock: set with the unlocking instruction, gone after the next one
    assign next_protectWindow = protectSet ? 1'b1
                              : (protectPending ? 1'b1 : (instrEnd ? 1'b0 : protectWindow));

    // unlock tracking; a new unlock wins over the closing instruction end
    always_ff @(posedge clock) begin
        if (rst) begin
            protectPending <= 1'b0;
            protectWindow <= 1'b0;
        end else begin
            protectPending <= protectSet & ~instrEnd;
            protectWindow <= next_protectWindow;
        end
    end

    // one slice per port; masks differ only on ports 3 and 4
    for (genvar s = 0; s < 6; s++) begin : g_port
        localparam logic [7:0] DMASK = (s == 3) ? `DIR_MASK_P3 : ((s == 4) ? `DIR_MASK_P4 : `DIR_MASK_FULL);
        localparam logic [7:0] AMASK = (s == 3) ? `DATA_MASK_P3 : ((s == 4) ? `DATA_MASK_P4 : `DIR_MASK_FULL);
        localparam logic [7:0] IMASK = (s == 4) ? `IN_ONLY_P4 : `IN_ONLY_NONE;

        // port 0 direction writes only inside the unlock window
        assign writeDirEn[s] = acc.write & acc.isDirection & (acc.port == 3'(s))
                             & ((s != 0) | protectWindow);
        assign writeDataEn[s] = acc.write & ~acc.isDirection & (acc.port == 3'(s));

        port_slice #(
            .DIR_MASK(DMASK),
            .DATA_MASK(AMASK),
            .IN_ONLY(IMASK),
            .WIDTH(8)
        ) u_slice (
            .clock(clock),
            .rst(rst),
            .writeDir(writeDirEn[s]),
            .writeData(writeDataEn[s]),
            .wdata(acc.data),
            .pinLevel(pinLevel[s]),
            .periphOe(periphOe[s]),
            .periphOut(periphOut[s]),
            .blocked(blocked[s]),
            .pullSel(pullGroup[s]),
            .dirBits(dirState[s]),
            .latch(latchState[s]),
            .readValue(readValue[s]),
            .padOut(padOut[s]),
            .padOe(padOe[s]),
            .pullOn(pullOn[s])
        );

        // pad controls registered so every output leaves a flop
        always_ff @(posedge clock) begin
            if (rst) begin
                pinOut[s] <= 8'h00;
                pinOutEn[s] <= 8'h00;
                pullupEn[s] <= 8'h00;
                driveHigh[s] <= 8'h00;
                periphIn[s] <= 8'h00;
            end else begin
                pinOut[s] <= padOut[s];
                pinOutEn[s] <= padOe[s];
                pullupEn[s] <= pullOn[s];
                driveHigh[s] <= driveGroup[s] & DMASK & ~blocked[s];
                periphIn[s] <= pinLevel[s] & AMASK & ~blocked[s];
            end
        end

        // reserved code keeps the previous threshold
        always_ff @(posedge clock) begin
            if (rst)
                thresholdLevel[s] <= `THRESHOLD_RESET;
            else if (thresholdCode[s] != `THRESHOLD_RESERVED)
                thresholdLevel[s] <= thresholdCode[s];
        end
    end

    // read selection; a missing slot reads zero
    assign portValid = (acc.port < 3'h6);
    assign selDir = portValid ? dirState[acc.port] : 8'h00;
    assign selData = portValid ? readValue[acc.port] : 8'h00;
    assign next_readData = acc.read ? (acc.isDirection ? selDir : selData) : readData;

    // read data appears the cycle after the strobe and then holds
    always_ff @(posedge clock) begin
        if (rst)
            readData <= 8'h00;
        else
            readData <= next_readData;
    end

    // input-mode read returns the sampled pin level
    property p_readInput;
        @(posedge clock) disable iff (rst)
        (acc.read && !acc.isDirection && acc.port == 3'h2 && dirState[2] == 8'h00)
            |=> readData == $past(pinLevel[2]);
    endproperty
    a_readInput: assert property (p_readInput) else $error("input read did not return pin level");

    // output-mode read returns the latch, not the pin
    property p_readLatch;
        @(posedge clock) disable iff (rst)
        (acc.read && !acc.isDirection && acc.port == 3'h1 && dirState[1] == 8'hff)
            |=> readData == $past(latchState[1]);
    endproperty
    a_readLatch: assert property (p_readLatch) else $error("output read did not return latch");

    // a data write reaches the latch even in input mode
    property p_writeLatch;
        @(posedge clock) disable iff (rst)
        (acc.write && !acc.isDirection && acc.port == 3'h2 && dirState[2] == 8'h00)
            |=> latchState[2] == $past(acc.data) ##1 pinOutEn[2] == 8'h00;
    endproperty
    a_writeLatch: assert property (p_writeLatch) else $error("latch write lost or driven");

    // output mode drives the latch one cycle on
    property p_driveLatch;
        @(posedge clock) disable iff (rst)
        (dirState[1][5] && !periphOe[1][5]) |=> (pinOutEn[1][5] && pinOut[1][5] == $past(latchState[1][5]));
    endproperty
    a_driveLatch: assert property (p_driveLatch) else $error("output mode pin not driven from latch");

    // peripheral output drives even in input mode
    property p_periphOverride;
        @(posedge clock) disable iff (rst)
        (periphOe[5][7] && !dirState[5][7]) |=> (pinOutEn[5][7] && pinOut[5][7] == $past(periphOut[5][7]));
    endproperty
    a_periphOverride: assert property (p_periphOverride) else $error("peripheral output not driven");

    // converter pin never drives nor pulls up
    property p_adcPin;
        @(posedge clock) disable iff (rst)
        !pinOutEn[4][2] && !pullupEn[4][2] && !driveHigh[4][2] && !dirState[4][2];
    endproperty
    a_adcPin: assert property (p_adcPin) else $error("converter pin has output features");

    // pull-up dropped the cycle after output mode is chosen
    property p_pullInput;
        @(posedge clock) disable iff (rst)
        dirState[0][0] |=> !pullupEn[0][0];
    endproperty
    a_pullInput: assert property (p_pullInput) else $error("pull-up active in output mode");

    // absent direction bits stay zero and read as zero
    property p_absentDir;
        @(posedge clock) disable iff (rst)
        (acc.read && acc.isDirection && acc.port == 3'h4) |=> (readData[2:0] == 3'h0 && dirState[3][6] == 1'b0);
    endproperty
    a_absentDir: assert property (p_absentDir) else $error("absent direction bit reads one");

    // oscillator pins released from output while in use
    property p_subClock;
        @(posedge clock) disable iff (rst)
        subClockInUse [*2] |-> pinOutEn[4][4:3] == 2'b00;
    endproperty
    a_subClock: assert property (p_subClock) else $error("sub clock pin driven");

    property p_mainClock;
        @(posedge clock) disable iff (rst)
        mainClockInUse |=> (pinOutEn[4][7:6] == 2'b00 && pullupEn[4][7:6] == 2'b00);
    endproperty
    a_mainClock: assert property (p_mainClock) else $error("main clock pin driven");

    // port 0 direction unchanged by a write outside the window
    property p_protect;
        @(posedge clock) disable iff (rst)
        (acc.write && acc.isDirection && acc.port == 3'h0 && !protectWindow) |=> $stable(dirState[0]);
    endproperty
    a_protect: assert property (p_protect) else $error("locked direction write took effect");

    // window closes within one instruction after it opens
    property p_protectClose;
        @(posedge clock) disable iff (rst)
        (protectWindow && !protectPending && instrEnd && !protectSet) |=> !protectWindow;
    endproperty
    a_protectClose: assert property (p_protectClose) else $error("unlock window outlived its instruction");

    // reserved threshold code is ignored
    property p_threshold;
        @(posedge clock) disable iff (rst)
        (cfg.thresholdSelectA[3:2] == 2'h3) |=> $stable(thresholdLevel[1]);
    endproperty
    a_threshold: assert property (p_threshold) else $error("reserved threshold accepted");
endmodule

// [sim/pin_partner.sv]
`timescale 1ns/1ps
// external parts hanging on the port pins
module pin_partner (
    input wire logic clock,
    input wire logic [5:0][7:0] pinOut, // device pin values
    input wire logic [5:0][7:0] pinOutEn, // high while the device drives
    input wire logic [5:0][7:0] pullupEn, // internal pull-up on
    input wire logic [5:0][7:0] extLevel, // level the outside part drives
    input wire logic [5:0][7:0] extFloat, // outside part released
    output logic [5:0][7:0] pinIn
);
    logic [5:0][7:0] wander = '0; // noise on lines nobody holds

    // toggles every cycle so a floating line never looks stable
    always @(posedge clock) begin
        wander <= ~wander;
    end

    // outside part backs off where the device drives, avoiding contention
    always_comb begin
        for (int s = 0; s < 6; s++) begin
            pinIn[s] = (pinOut[s] & pinOutEn[s]) | (~pinOutEn[s] & ~extFloat[s] & extLevel[s])
                | (~pinOutEn[s] & extFloat[s] & (pullupEn[s] | wander[s]));
        end
    end
endmodule

// [sim/io_port_direction_latch_bench.sv]
`timescale 1ns/1ps
module io_port_direction_latch_bench;
    import gpio_pkg::*;
    typedef struct {
        logic [2:0] slot;
        logic [7:0] dir, data, ext, rd, en;
    } row_t;
    // slot, direction, latch, outside level, expected read, expected enable
    row_t rows[4] = '{'{3'h1, 8'hff, 8'ha5, 8'h5a, 8'ha5, 8'hff}, '{3'h2, 8'h00, 8'h3c, 8'hc3, 8'hc3, 8'h00},
        '{3'h5, 8'h0f, 8'h96, 8'h69, 8'h66, 8'h0f}, '{3'h3, 8'hff, 8'hff, 8'h00, 8'hbb, 8'hbb}};
    row_t r;
    logic clock = 1'b0;
    logic rst = 1'b1;
    access_t acc = '0;
    pad_cfg_t cfg = '0;
    logic protectSet = 1'b0;
    logic instrEnd = 1'b0;
    logic adcInUse = 1'b0;
    logic subClockInUse = 1'b0;
    logic mainClockInUse = 1'b0;
    logic [5:0][7:0] periphOe = '0;
    logic [5:0][7:0] periphOut = '0;
    logic [5:0][7:0] extLevel = '0;
    logic [5:0][7:0] extFloat = '0;
    wire logic [5:0][7:0] pinIn;
    logic [7:0] readData, v;
    logic [5:0][7:0] pinOut, pinOutEn, pullupEn, driveHigh, periphIn;
    logic [5:0][1:0] thresholdLevel;
    int err_count = 0;
    int n_tests = 0;

    always #5 clock = ~clock;

    io_port_direction_latch #(.NUM_PORTS(6)) DUT (.clock(clock), .rst(rst), .acc(acc), .cfg(cfg),
        .protectSet(protectSet), .instrEnd(instrEnd), .adcInUse(adcInUse), .subClockInUse(subClockInUse),
        .mainClockInUse(mainClockInUse), .pinIn(pinIn), .periphOe(periphOe), .periphOut(periphOut),
        .readData(readData), .pinOut(pinOut), .pinOutEn(pinOutEn), .pullupEn(pullupEn),
        .driveHigh(driveHigh), .thresholdLevel(thresholdLevel), .periphIn(periphIn));

    pin_partner ext (.clock(clock), .pinOut(pinOut), .pinOutEn(pinOutEn), .pullupEn(pullupEn),
        .extLevel(extLevel), .extFloat(extFloat), .pinIn(pinIn));

    // one compare, counted; mismatch reported at once
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // single-cycle register access, launched just after an edge
    task automatic access(input logic wr, input logic rd, input logic isDir, input logic [2:0] port,
        input logic [7:0] data);
        @(posedge clock) #1;
        acc = '{write: wr, read: rd, isDirection: isDir, port: port, data: data};
        @(posedge clock) #1;
        acc = '0;
    endtask

    // read lands in readData at the taking edge
    task automatic rd(input logic isDir, input logic [2:0] port, output logic [7:0] val);
        access(1'b0, 1'b1, isDir, port, 8'h00);
        val = readData;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic test_done();
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        #100us;
        err_count++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge clock);
        #1;
        rst = 1'b0;
        tick(1);
        check(pinOutEn, '0);
        check(thresholdLevel, '0);
        // ordinary cases: direction, latch, outside level per slot
        foreach (rows[i]) begin
            r = rows[i];
            access(1'b1, 1'b0, 1'b1, r.slot, r.dir);
            access(1'b1, 1'b0, 1'b0, r.slot, r.data);
            extLevel[r.slot] = r.ext;
            tick(3);
            rd(1'b0, r.slot, v);
            check(v, r.rd);
            check(pinOutEn[r.slot], r.en);
            check(pinOut[r.slot] & r.en, r.data & r.en);
            rd(1'b1, r.slot, v);
            check(v, r.en);
        end
        // port 4: gaps at 0..2, bit 2 input only
        extLevel[4] = 8'hff;
        access(1'b1, 1'b0, 1'b1, 3'h4, 8'hff);
        access(1'b1, 1'b0, 1'b0, 3'h4, 8'hff);
        tick(3);
        rd(1'b1, 3'h4, v);
        check(v, 8'hf8);
        rd(1'b0, 3'h4, v);
        check(v, 8'hfc);
        // oscillators and converter take their pins away
        adcInUse = 1'b1;
        subClockInUse = 1'b1;
        mainClockInUse = 1'b1;
        tick(2);
        check(pinOutEn[4], 8'h20);
        rd(1'b0, 3'h4, v);
        check(v, 8'h20);
        adcInUse = 1'b0;
        subClockInUse = 1'b0;
        mainClockInUse = 1'b0;
        tick(2);
        check(pinOutEn[4], 8'hf8);
        // latch written in input mode shows once output is chosen
        access(1'b1, 1'b0, 1'b1, 3'h2, 8'hff);
        tick(2);
        check(pinOut[2], 8'h3c);
        check(pinOutEn[2], 8'hff);
        // peripheral output drives an input-mode pin, latch bit 7 is 1
        periphOe[5] = 8'h80;
        tick(2);
        check(pinOutEn[5], 8'h8f);
        check(pinOut[5] & 8'h80, 8'h00);
        // pull-up only while in input mode
        cfg.pullupSelectRegA = 8'h30;
        tick(2);
        check(pullupEn[2], 8'h00);
        access(1'b1, 1'b0, 1'b1, 3'h2, 8'h0f);
        extFloat[2] = 8'hf0;
        tick(3);
        check(pullupEn[2], 8'hf0);
        rd(1'b0, 3'h2, v);
        check(v, 8'hfc);
        check(periphIn[2], 8'hfc);
        // drive strength and thresholds, reserved code keeps the old level
        cfg.driveSelectPortB = 8'h5a;
        cfg.thresholdSelectA = 8'h06;
        tick(2);
        check(driveHigh[1], 8'h5a);
        check(thresholdLevel[0], TH_HIGH);
        check(thresholdLevel[1], TH_MID);
        cfg.thresholdSelectA = 8'h0e;
        tick(2);
        check(thresholdLevel[1], TH_MID);
        // unmapped slot
        access(1'b1, 1'b0, 1'b0, 3'h6, 8'hff);
        rd(1'b0, 3'h6, v);
        check(v, 8'h00);
        // port 0 direction locked until the unlock instruction
        access(1'b1, 1'b0, 1'b1, 3'h0, 8'hff);
        rd(1'b1, 3'h0, v);
        check(v, 8'h00);
        protectSet = 1'b1;
        instrEnd = 1'b1;
        tick(1);
        protectSet = 1'b0;
        instrEnd = 1'b0;
        access(1'b1, 1'b0, 1'b1, 3'h0, 8'hff);
        instrEnd = 1'b1;
        tick(1);
        instrEnd = 1'b0;
        access(1'b1, 1'b0, 1'b1, 3'h0, 8'h00);
        rd(1'b1, 3'h0, v);
        check(v, 8'hff);
        // mid-run reset clears direction and drive
        rst = 1'b1;
        tick(3);
        rst = 1'b0;
        tick(1);
        // peripheral enable on port 6 bit 7 is still up, so that pin drives at once
        check(pinOutEn, 48'h800000000000);
        check(readData, 8'h00);
        rd(1'b1, 3'h1, v);
        check(v, 8'h00);
        test_done();
    end
endmodule
